//--- verilog/vspo_pixel_out.sv
`include "vspo_defines.svh"
// Contract
// - Pixel clock is half master clock rate
// - Output enable high turns data drivers off
// - Reset low resets asynchronously to defaults
// - Standby high stops imaging
// - Ten-bit pixel word, bit 0 least
// - Frame-valid high during valid frame
// - Line-valid per line, format selectable
// - Array addressed as 668 by 496
// - First 18 columns, 6 rows black
// - Last column and row also black
// - First 6 black rows drive automatic black level
// - Active region 649 by 489 pixels
// - Even rows green/red, odd blue/green
// - Even columns green/blue, odd complementary
// - Progressive scan with horizontal, vertical blanking
// - Blanking lengths each set by register
module vspo_pixel_out #(
  parameter int COLS = `VSPO_ARRAY_COLS,
  parameter int ROWS = `VSPO_ARRAY_ROWS,
  parameter int BLACK_COLS = `VSPO_BLACK_COLS,
  parameter int BLACK_ROWS = `VSPO_BLACK_ROWS,
  parameter int PW = 10,
  parameter int CW = 12
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic MASTER_CLOCK_IN_I,
  input wire logic OE_B_I,
  input wire logic STANDBY_I,
  input wire logic SCAN_EN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  output logic [CW-1:0] PIX_ROW_O,
  output logic [CW-1:0] PIX_COL_O,
  input wire logic [PW-1:0] PIX_I,
  output logic PIXEL_CLOCK_OUT_O,
  output logic [PW-1:0] DATA_O,
  output logic DATA_OE_B_O,
  output logic FRAME_VALID_O,
  output logic LINE_VALID_O,
  output logic [1:0] PIX_COLOUR_O,
  output logic PIX_BLACK_O
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic vspo_pkg::vspo_colour_e colour_of(
    input logic row_odd,
    input logic col_odd
  );
    vspo_pkg::vspo_colour_e c;
    c = vspo_pkg::COL_GREEN;
    if (!row_odd && col_odd)
      c = vspo_pkg::COL_RED;
    else if (row_odd && !col_odd)
      c = vspo_pkg::COL_BLUE;
    return c;
  endfunction

  function automatic logic is_black(
    input logic [CW-1:0] r,
    input logic [CW-1:0] c
  );
    logic b;
    b = (c < CW'(BLACK_COLS)) || (r < CW'(BLACK_ROWS));
    b = b || (c == CW'(COLS - 1)) || (r == CW'(ROWS - 1));
    return b;
  endfunction

  function automatic logic [PW-1:0] clamp_pix(
    input logic signed [PW+1:0] v
  );
    logic [PW-1:0] o;
    o = v[PW-1:0];
    if (v < 0)
      o = '0;
    else if (v > $signed({2'b00, {PW{1'b1}}}))
      o = {PW{1'b1}};
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] mclk_sync;
  logic mclk_prev;
  logic [1:0] oe_sync;
  logic [1:0] stby_sync;
  logic [1:0] scan_sync;
  logic mclk_rise;

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mclk_sync <= 2'h0;
      mclk_prev <= 1'b0;
    end
    else
    begin
      mclk_sync <= {mclk_sync[0], MASTER_CLOCK_IN_I};
      mclk_prev <= mclk_sync[1];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oe_sync <= 2'h3;
      stby_sync <= 2'h0;
      scan_sync <= 2'h0;
    end
    else
    begin
      oe_sync <= {oe_sync[0], OE_B_I};
      stby_sync <= {stby_sync[0], STANDBY_I};
      scan_sync <= {scan_sync[0], SCAN_EN_I};
    end
  end

  // Core clock must see each master clock level at least twice
  assign mclk_rise = mclk_sync[1] && !mclk_prev;

  // ----------------------------------------------------------------
  // Pixel clock
  // ----------------------------------------------------------------
  logic step;

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      PIXEL_CLOCK_OUT_O <= 1'b0;
    else if (mclk_rise)
      PIXEL_CLOCK_OUT_O <= !PIXEL_CLOCK_OUT_O;
  end

  // Outputs move on the falling pixel clock edge
  assign step = mclk_rise && PIXEL_CLOCK_OUT_O;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [`VSPO_HBLANK_W-1:0] hblank;
  logic [`VSPO_VBLANK_W-1:0] vblank;
  logic lv_cont;
  logic [PW-1:0] blk;
  vspo_pkg::vspo_state_e state;

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hblank <= `VSPO_HBLANK_RST;
      vblank <= `VSPO_VBLANK_RST;
      lv_cont <= `VSPO_LVFMT_RST;
    end
    else if (REG_WR_I)
    begin
      if (REG_ADDR_I == `VSPO_REG_HBLANK)
        hblank <= REG_WDATA_I[`VSPO_HBLANK_W-1:0];
      if (REG_ADDR_I == `VSPO_REG_VBLANK)
        vblank <= REG_WDATA_I[`VSPO_VBLANK_W-1:0];
      if (REG_ADDR_I == `VSPO_REG_LVFMT)
        lv_cont <= REG_WDATA_I[`VSPO_LVFMT_CONT_BIT];
    end
  end

  logic [15:0] next_rdata;
  logic [15:0] status;

  always_comb
  begin
    status = 16'h0000;
    status[`VSPO_ST_RUN_BIT] = (state == vspo_pkg::ST_RUN);
    status[`VSPO_ST_FV_BIT] = FRAME_VALID_O;
    status[`VSPO_ST_LV_BIT] = LINE_VALID_O;
    status[`VSPO_ST_SCAN_BIT] = scan_sync[1];
    status[`VSPO_ST_STBY_BIT] = stby_sync[1];
    status[`VSPO_ST_OEB_BIT] = oe_sync[1];
  end

  always_comb
  begin
    next_rdata = 16'h0000;
    unique case (REG_ADDR_I)
      `VSPO_REG_HBLANK: next_rdata = 16'(hblank);
      `VSPO_REG_VBLANK: next_rdata = 16'(vblank);
      `VSPO_REG_LVFMT: next_rdata = 16'(lv_cont);
      `VSPO_REG_STATUS: next_rdata = status;
      `VSPO_REG_ROWPOS: next_rdata = 16'(PIX_ROW_O);
      `VSPO_REG_BLACK: next_rdata = 16'(blk);
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      REG_RDATA_O <= 16'h0000;
    else if (REG_RD_I)
      REG_RDATA_O <= next_rdata;
    else
      REG_RDATA_O <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Scan state
  // ----------------------------------------------------------------
  logic scan_en;
  logic col_wrap;
  logic row_wrap;
  logic [CW-1:0] col_limit;
  logic [CW-1:0] row_limit;

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      state <= vspo_pkg::ST_IDLE;
    else
    begin
      unique case (state)
        vspo_pkg::ST_IDLE:
          if (step && !stby_sync[1])
            state <= vspo_pkg::ST_RUN;
        vspo_pkg::ST_RUN:
          if (stby_sync[1])
            state <= vspo_pkg::ST_IDLE;
      endcase
    end
  end

  assign scan_en = step && (state == vspo_pkg::ST_RUN);
  assign col_limit = CW'(COLS - 1) + CW'(hblank);
  assign row_limit = CW'(ROWS - 1) + CW'(vblank);

  // ----------------------------------------------------------------
  // Column and row counters
  // ----------------------------------------------------------------
  vspo_scan_counter #(
    .W(CW)
  ) u_col (
    .clk_i(CORE_CLK_I),
    .rst_n_i(rst_n),
    .en_i(scan_en),
    .clr_i(state == vspo_pkg::ST_IDLE),
    .limit_i(col_limit),
    .count_o(PIX_COL_O),
    .wrap_o(col_wrap)
  );

  vspo_scan_counter #(
    .W(CW)
  ) u_row (
    .clk_i(CORE_CLK_I),
    .rst_n_i(rst_n),
    .en_i(col_wrap),
    .clr_i(state == vspo_pkg::ST_IDLE),
    .limit_i(row_limit),
    .count_o(PIX_ROW_O),
    .wrap_o(row_wrap)
  );

  // ----------------------------------------------------------------
  // Black level
  // ----------------------------------------------------------------
  logic in_frame;
  logic in_line;
  logic black_here;
  logic signed [PW:0] blk_diff;
  logic signed [PW:0] blk_sum;
  logic signed [PW+1:0] adj;

  assign in_frame = PIX_ROW_O < CW'(ROWS);
  assign in_line = in_frame && (PIX_COL_O < CW'(COLS));
  assign black_here = is_black(PIX_ROW_O, PIX_COL_O);
  assign blk_diff = $signed({1'b0, PIX_I}) - $signed({1'b0, blk});
  assign blk_sum = $signed({1'b0, blk})
    + (blk_diff >>> `VSPO_BLACK_SHIFT);

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      blk <= `VSPO_BLACK_TARGET;
    else if (scan_en && in_line && PIX_ROW_O < CW'(BLACK_ROWS))
      blk <= blk_sum[PW-1:0];
  end

  // Active pixels pulled to the black target level
  assign adj = $signed({2'b00, PIX_I}) - $signed({2'b00, blk})
    + $signed({2'b00, `VSPO_BLACK_TARGET});

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      FRAME_VALID_O <= 1'b0;
      LINE_VALID_O <= 1'b0;
    end
    else if (state == vspo_pkg::ST_IDLE)
    begin
      FRAME_VALID_O <= 1'b0;
      LINE_VALID_O <= 1'b0;
    end
    else if (scan_en)
    begin
      FRAME_VALID_O <= in_frame;
      // Continuous format fills horizontal blanking inside the frame
      LINE_VALID_O <= lv_cont ? in_frame : in_line;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      DATA_O <= '0;
      PIX_COLOUR_O <= 2'h0;
      PIX_BLACK_O <= 1'b0;
    end
    else if (state == vspo_pkg::ST_IDLE)
    begin
      DATA_O <= '0;
      PIX_COLOUR_O <= 2'h0;
      PIX_BLACK_O <= 1'b0;
    end
    else if (scan_en)
    begin
      if (!in_line)
        DATA_O <= '0;
      else if (black_here)
        DATA_O <= PIX_I;
      else
        DATA_O <= clamp_pix(adj);
      PIX_COLOUR_O <= colour_of(PIX_ROW_O[0], PIX_COL_O[0]);
      PIX_BLACK_O <= in_line && black_here;
    end
  end

  // Drivers off while the enable pin is high
  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      DATA_OE_B_O <= 1'b1;
    else
      DATA_OE_B_O <= oe_sync[1];
  end

  // Frame wrap restarts at row zero once the vblank rows have passed
  logic unused_wrap;
  assign unused_wrap = row_wrap;

endmodule

//--- pkg/vspo_defines.svh
`ifndef VSPO_DEFINES_SVH
`define VSPO_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VSPO_REG_HBLANK 8'h05
`define VSPO_REG_VBLANK 8'h06
`define VSPO_REG_LVFMT 8'h20
`define VSPO_REG_STATUS 8'h30
`define VSPO_REG_ROWPOS 8'h31
`define VSPO_REG_BLACK 8'h32

// ----------------------------------------------------------------
// Reset values and field widths
// ----------------------------------------------------------------
`define VSPO_HBLANK_RST 10'h00a
`define VSPO_VBLANK_RST 11'h019
`define VSPO_LVFMT_RST 1'b0
`define VSPO_HBLANK_W 10
`define VSPO_VBLANK_W 11
`define VSPO_LVFMT_CONT_BIT 0

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define VSPO_ST_RUN_BIT 0
`define VSPO_ST_FV_BIT 1
`define VSPO_ST_LV_BIT 2
`define VSPO_ST_SCAN_BIT 3
`define VSPO_ST_STBY_BIT 4
`define VSPO_ST_OEB_BIT 5

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define VSPO_ARRAY_COLS 668
`define VSPO_ARRAY_ROWS 496
`define VSPO_BLACK_COLS 18
`define VSPO_BLACK_ROWS 6
`define VSPO_ACTIVE_COLS 649
`define VSPO_ACTIVE_ROWS 489

// ----------------------------------------------------------------
// Clocks and black level
// ----------------------------------------------------------------
`define VSPO_MCLK_MAX_HZ 27000000
`define VSPO_CORE_HZ 125000000
`define VSPO_BLACK_TARGET 10'h02a
`define VSPO_BLACK_SHIFT 4

`endif

//--- pkg/vspo_pkg.sv
package vspo_pkg;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } vspo_state_e;

  typedef enum logic [1:0] {
    COL_GREEN,
    COL_RED,
    COL_BLUE
  } vspo_colour_e;

endpackage

//--- verilog/vspo_scan_counter.sv
// ----------------------------------------------------------------
// Wrapping position counter
// ----------------------------------------------------------------
module vspo_scan_counter #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic [W-1:0] limit_i,
  output logic [W-1:0] count_o,
  output logic wrap_o
);

  // Greater-or-equal so a shrunk limit never strands the count
  assign wrap_o = en_i && (count_o >= limit_i);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_o <= '0;
    else if (clr_i)
      count_o <= '0;
    else if (en_i)
    begin
      if (wrap_o)
        count_o <= '0;
      else
        count_o <= count_o + 1'b1;
    end
  end

endmodule

//--- bench/vspo_pixel_out_monitor.sv
// ---
// Pixel link checks
// ---
module vspo_pixel_out_monitor #(
  parameter int PW = 10
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic MASTER_CLOCK_IN_I,
  input wire logic OE_B_I,
  input wire logic STANDBY_I,
  input wire logic PIXEL_CLOCK_OUT_O,
  input wire logic [PW-1:0] DATA_O,
  input wire logic DATA_OE_B_O,
  input wire logic FRAME_VALID_O,
  input wire logic LINE_VALID_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] live;

  // Hold checks off until the pin syncs have settled
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      live <= 3'h0;
    else if (live != 3'h7)
      live <= live + 3'h1;
  end

  default clocking @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_B_I || live != 3'h7);

  chk_lv_in_fv: assert property (LINE_VALID_O |-> FRAME_VALID_O)
    else $error("line valid outside frame");
  chk_frame_opens: assert property ($rose(FRAME_VALID_O) |-> LINE_VALID_O)
    else $error("frame opened without line");
  chk_blank_zero: assert property ($fell(LINE_VALID_O) |-> DATA_O == '0)
    else $error("data not zero in blanking");
  chk_oe_off: assert property (OE_B_I [*4] |-> DATA_OE_B_O)
    else $error("drivers left on");
  chk_oe_on: assert property (!OE_B_I [*4] |-> !DATA_OE_B_O)
    else $error("drivers left off");
  chk_standby_idle: assert property (STANDBY_I [*5] |-> !FRAME_VALID_O
    && !LINE_VALID_O && DATA_O == '0) else $error("imaging in standby");
  chk_pclk_follow: assert property ($rose(MASTER_CLOCK_IN_I) |->
    ##[2:5] $changed(PIXEL_CLOCK_OUT_O)) else $error("pixel clock lagged");
  chk_pclk_steady: assert property ($changed(PIXEL_CLOCK_OUT_O) |=>
    $stable(PIXEL_CLOCK_OUT_O) [*7]) else $error("pixel clock too fast");
  chk_step_on_fall: assert property (!STANDBY_I [*5] ##0
    $changed({DATA_O, FRAME_VALID_O, LINE_VALID_O}) |->
    $fell(PIXEL_CLOCK_OUT_O)) else $error("output changed off the step");

  cov_frame: cover property ($rose(FRAME_VALID_O));
  cov_hblank: cover property (FRAME_VALID_O && $fell(LINE_VALID_O));
  cov_standby: cover property ($rose(STANDBY_I));
endmodule

bind vspo_pixel_out vspo_pixel_out_monitor #(.PW(PW)) i_mon (
  .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
  .MASTER_CLOCK_IN_I(MASTER_CLOCK_IN_I), .OE_B_I(OE_B_I),
  .STANDBY_I(STANDBY_I), .PIXEL_CLOCK_OUT_O(PIXEL_CLOCK_OUT_O),
  .DATA_O(DATA_O), .DATA_OE_B_O(DATA_OE_B_O),
  .FRAME_VALID_O(FRAME_VALID_O), .LINE_VALID_O(LINE_VALID_O)
);

//--- bench/vspo_host_model.sv
// ---
// Host capture of the pixel bus
// ---
module vspo_host_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pclk_i,
  input wire logic fv_i,
  input wire logic lv_i,
  input wire logic [9:0] data_i,
  input wire logic oe_b_i,
  output logic cap_o,
  output logic [9:0] cap_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pclk_q <= 1'b0;
      cap_o <= 1'b0;
      cap_data_o <= 10'h000;
    end
    else
    begin
      pclk_q <= pclk_i;
      cap_o <= pclk_i && !pclk_q && fv_i && lv_i;
      // Released bus reads back as the last capture inverted
      if (pclk_i && !pclk_q && fv_i && lv_i)
        cap_data_o <= oe_b_i ? ~cap_data_o : data_i;
    end
  end
endmodule

//--- bench/test_vspo_pixel_out.sv
module test_vspo_pixel_out;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int COLS = 24;
  localparam int ROWS = 10;
  logic core_clk, rst_b, mclk, oe_b, stby, quiet, pclk_q, reg_wr, reg_rd;
  logic pclk, data_oe_b, fv, lv, black, cap;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [11:0] row, col;
  logic [9:0] pix, data, cap_data, salt;
  logic [1:0] colour;
  logic [13:0] exp_q[$];
  int failures, total_checks, seed, hblank, gap;

  vspo_pixel_out #(.COLS(COLS), .ROWS(ROWS)) i_dut (
    .CORE_CLK_I(core_clk), .RST_B_I(rst_b), .MASTER_CLOCK_IN_I(mclk),
    .OE_B_I(oe_b), .STANDBY_I(stby), .SCAN_EN_I(1'b0),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .PIX_ROW_O(row),
    .PIX_COL_O(col), .PIX_I(pix), .PIXEL_CLOCK_OUT_O(pclk), .DATA_O(data),
    .DATA_OE_B_O(data_oe_b), .FRAME_VALID_O(fv), .LINE_VALID_O(lv),
    .PIX_COLOUR_O(colour), .PIX_BLACK_O(black));
  vspo_host_model i_host (
    .clk_i(core_clk), .rst_n_i(rst_b), .pclk_i(pclk), .fv_i(fv),
    .lv_i(lv), .data_i(data), .oe_b_i(data_oe_b), .cap_o(cap),
    .cap_data_o(cap_data));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial
  begin
    mclk = 1'b0;
    #3;
    forever #40 mclk = ~mclk;
  end

  // Black rows sit at the target so the level estimate stays put
  function automatic logic [9:0] pixel_of(input int r, input int c);
    return (r < 6) ? 10'h02a : 10'(r * 37 + c * 5) ^ salt;
  endfunction

  function automatic logic [13:0] expect_of(input int r, input int c);
    logic [1:0] k;
    k = (r % 2) ? ((c % 2) ? vspo_pkg::COL_GREEN : vspo_pkg::COL_BLUE)
      : ((c % 2) ? vspo_pkg::COL_RED : vspo_pkg::COL_GREEN);
    return {1'b0, pixel_of(r, c), k,
      (c < 18 || r < 6 || c == COLS - 1 || r == ROWS - 1)};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic reg_op(input logic wr, input logic [7:0] a,
                        input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!wr)
      check(reg_rdata, d);
    @(posedge core_clk);
  endtask

  task automatic run_frame(input logic fmt);
    int n;
    reg_op(1'b1, 8'h20, {15'h0000, fmt});
    for (int r = 0; r < ROWS; r++)
    begin
      for (int c = 0; c < COLS; c++)
        exp_q.push_back(expect_of(r, c));
      if (fmt)
        repeat (hblank) exp_q.push_back(14'h2000);
    end
    stby <= 1'b0;
    for (n = 0; n < 20000 && exp_q.size() > 0; n++)
      @(posedge core_clk);
    check(16'(exp_q.size()), 16'h0000);
    stby <= 1'b1;
    repeat (8) @(posedge core_clk);
    check({fv, lv, 4'h0, data}, 16'h0000);
  endtask

  always @(posedge core_clk)
    pix <= pixel_of(int'(row), int'(col));

  always @(posedge core_clk)
  begin
    if (cap && !quiet)
    begin
      if (exp_q.size() == 0)
        check(16'h0001, 16'h0000);
      else if (exp_q[0][13])
        check(16'(cap_data), 16'(exp_q[0][12:3]));
      else
        check(16'({cap_data, colour, black}), 16'(exp_q[0]));
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
  end

  // Count pixel periods with line valid low inside a frame
  always @(posedge core_clk)
  begin
    pclk_q <= pclk;
    if (!fv || (pclk && !pclk_q && lv))
      gap <= 0;
    else if (pclk && !pclk_q)
      gap <= gap + 1;
    if (pclk && !pclk_q && lv && gap > 0)
      check(16'(gap), 16'(hblank));
  end

  initial
  begin
    #400us;
    failures++;
    finish_test();
  end

  initial
  begin
    seed = 59;
    rst_b = 1'b0;
    oe_b = 1'b0;
    stby = 1'b1;
    quiet = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pix = 10'h000;
    salt = 10'($random(seed));
    hblank = 2 + ($random(seed) & 3);
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge core_clk);
    reg_op(1'b0, 8'h05, 16'h000a);
    reg_op(1'b0, 8'h06, 16'h0019);
    reg_op(1'b0, 8'h20, 16'h0000);
    reg_op(1'b0, 8'h07, 16'h0000);
    reg_op(1'b1, 8'h30, 16'hffff);
    reg_op(1'b0, 8'h30, 16'h0010);
    reg_op(1'b1, 8'h05, 16'(hblank));
    reg_op(1'b1, 8'h06, 16'h0001);
    reg_op(1'b0, 8'h05, 16'(hblank));
    reg_op(1'b0, 8'h06, 16'h0001);
    oe_b <= 1'b1;
    repeat (6) @(posedge core_clk);
    check(16'(data_oe_b), 16'h0001);
    oe_b <= 1'b0;
    quiet <= 1'b0;
    run_frame(1'b0);
    run_frame(1'b1);
    // Black rows sat at target, so the estimate must not have moved
    reg_op(1'b0, 8'h32, 16'h002a);
    reg_op(1'b0, 8'h31, 16'h0000);
    quiet <= 1'b1;
    stby <= 1'b0;
    repeat (400) @(posedge core_clk);
    rst_b <= 1'b0;
    stby <= 1'b1;
    #1;
    check({13'h0000, data_oe_b, fv, lv}, 16'h0004);
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge core_clk);
    reg_op(1'b0, 8'h05, 16'h000a);
    reg_op(1'b0, 8'h06, 16'h0019);
    reg_op(1'b0, 8'h20, 16'h0000);
    finish_test();
  end
endmodule
